// file: rtl/pgrs_pkg.sv
/*
  Constants shared by the power-good and rail sequencer: register offsets, field positions,
  reset values and timing counts.
  Assumes a 25 MHz reference clock.
*/
package pgrs_pkg;
  localparam logic [7:0] STATUS_ADDR = 8'h0b;
  localparam logic [7:0] MASK_ADDR = 8'h0c;
  localparam logic [7:0] CTRL_ADDR = 8'h0d;
  // Status fields.
  localparam int COMP_BIT = 7;
  localparam int DELAY_LSB = 5;
  localparam int DELAY_MSB = 6;
  // Rail order in status, mask and good vectors.
  localparam int BUCK1_BIT = 4;
  localparam int BUCK2_BIT = 3;
  localparam int BUCK3_BIT = 2;
  localparam int LIN1_BIT = 1;
  localparam int LIN2_BIT = 0;
  localparam int PAIR_MASK_BIT = 5;
  localparam int SEQ_LSB = 5;
  localparam int SEQ_MSB = 7;
  localparam logic [1:0] DELAY_RESET = 2'h3;
  localparam logic [5:0] MASK_RESET = 6'h10;
  localparam logic [4:0] ENABLE_RESET = 5'h1f;
  localparam logic [2:0] SEQ_RESET = 3'h0;
  // Sequencing codes.
  localparam logic [2:0] SEQ_B2 = 3'h0;
  localparam logic [2:0] SEQ_B2B3 = 3'h1;
  localparam logic [2:0] SEQ_B1_B23 = 3'h2;
  localparam logic [2:0] SEQ_B3_B2 = 3'h3;
  localparam logic [2:0] SEQ_L2_B12 = 3'h4;
  localparam logic [2:0] SEQ_PINS = 3'h5;
  localparam logic [2:0] SEQ_B1_B2_B3 = 3'h6;
  localparam logic [2:0] SEQ_EXT_L2_B12 = 3'h7;
  // Timing, figures in milliseconds and the derived cycle counts.
  localparam int CLK_KHZ = 25000;
  localparam int DELAY0_MS = 20;
  localparam int DELAY1_MS = 100;
  localparam int DELAY2_MS = 200;
  localparam int DELAY3_MS = 400;
  localparam int GAP_MS = 1;
  localparam int DELAY0_CYC = DELAY0_MS * CLK_KHZ;
  localparam int DELAY1_CYC = DELAY1_MS * CLK_KHZ;
  localparam int DELAY2_CYC = DELAY2_MS * CLK_KHZ;
  localparam int DELAY3_CYC = DELAY3_MS * CLK_KHZ;
  localparam int GAP_CYC = GAP_MS * CLK_KHZ;
  localparam int DOWN_STEP_CYC = 25;
  localparam int CNT_W = 24;
  localparam int NSYNC = 12;
endpackage : pgrs_pkg

// file: rtl/pgrs_sequencer.sv
/*
  Power-good monitor and step-down converter sequencer with its three registers.
  Assumes a serial-interface front end on ref_clk that presents single-cycle register
  read and write strobes; rail good levels, enable pins, the comparator, lockout and
  ON-state level arrive asynchronously and are synchronised here.
*/
// Overview of operation
// - Status bit 7 reads 1 while the reset comparator input is below threshold.
// - Delay code 00/01/10/11 selects 20/100/200/400 ms for reset and good outputs.
// - Five read-only good bits show each rail in range, else 0.
// - Pair mask pulls good output low only when buck three and linreg one both fail.
// - Each single mask bit lets its failing rail pull the good output low.
// - A supply runs only with its control bit set and, outside the sequence, its enable pin high.
// - A low enable pin forces its control enable bits back to default.
// - Power-down walks the chosen power-up order in reverse.
// - Code 000 starts buck two only; buck one and three follow pins.
// - Code 001 starts buck two and three together; buck one follows its pin.
// - Code 010 starts buck one, then buck two and three once it is good.
// - Code 011 starts buck three, then buck two once it is good.
// - Code 100 starts linreg two (with buck three if overridden), then buck one and two.
// - Code 101 has no automatic sequence; each buck follows its own pin.
// - Code 110 starts buck one, two, three, each after the previous is good.
// - Code 111 starts buck one and two more than 1 ms after linreg two.
// - Automatic sequencing begins on entry to the ON state.
// - In ON state a buck outside the sequence follows its enable pin anytime.
// - Code 111 raises the external regulator enable before starting linreg two.
// - Mask and control writable fields reload defaults on undervoltage lockout.
`timescale 1ns/100ps
module pgrs_sequencer #(
  parameter int DELAY0_CYCLES = pgrs_pkg::DELAY0_CYC,
  parameter int DELAY1_CYCLES = pgrs_pkg::DELAY1_CYC,
  parameter int DELAY2_CYCLES = pgrs_pkg::DELAY2_CYC,
  parameter int DELAY3_CYCLES = pgrs_pkg::DELAY3_CYC,
  parameter int GAP_CYCLES = pgrs_pkg::GAP_CYC,
  parameter logic [2:0] SEQ_DEFAULT = pgrs_pkg::SEQ_RESET
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic reset_comp_below,
  input wire logic [4:0] rail_good_in,
  input wire logic buck_one_on_pin,
  input wire logic buck_two_on_pin,
  input wire logic buck_three_on_pin,
  input wire logic linreg_on_pin,
  input wire logic undervoltage_lockout,
  input wire logic on_state,
  input wire logic buck_three_pin_override,
  output logic [2:0] buck_on,
  output logic linreg_one_on,
  output logic linreg_two_on,
  output logic external_regulator_on_out,
  output logic rails_good_output,
  output logic reset_release_out
);
  // All state lives in one packed struct so that reset and the register stage stay together.
  // The synchroniser pairs sit at the top; nothing but the second stage is ever read.
  typedef struct packed {
    logic [pgrs_pkg::NSYNC-1:0] sync1;
    logic [pgrs_pkg::NSYNC-1:0] sync2;
    logic [1:0] delay_sel;
    logic [5:0] mask;
    logic [2:0] seq;
    logic [4:0] enables;
    logic [1:0] stage;
    logic [pgrs_pkg::CNT_W-1:0] step_cnt;
    logic [pgrs_pkg::CNT_W-1:0] good_cnt;
    logic [pgrs_pkg::CNT_W-1:0] rst_cnt;
    logic good_out;
    logic rst_out;
    logic ext_on;
    logic [2:0] buck;
    logic lin1;
    logic lin2;
    logic [7:0] rdata;
  } pgrs_state_s;

  pgrs_state_s cur;
  pgrs_state_s next_cur;

  // Stage at which a member joins the automatic sequence; 0 means pin controlled.
  // Member index: 0 buck one, 1 buck two, 2 buck three, 3 linreg two.
  function automatic logic [1:0] pgrs_group(input logic [2:0] code, input int idx,
                                            input logic ovr);
    logic [1:0] g [4];
    g = '{2'h0, 2'h0, 2'h0, 2'h0};
    case (code)
      pgrs_pkg::SEQ_B2: g[1] = 2'h1;
      pgrs_pkg::SEQ_B2B3:
      begin
        g[1] = 2'h1;
        g[2] = 2'h1;
      end
      pgrs_pkg::SEQ_B1_B23: g = '{2'h1, 2'h2, 2'h2, 2'h0};
      pgrs_pkg::SEQ_B3_B2:
      begin
        g[2] = 2'h1;
        g[1] = 2'h2;
      end
      pgrs_pkg::SEQ_L2_B12: g = '{2'h2, 2'h2, (ovr ? 2'h1 : 2'h0), 2'h1};
      pgrs_pkg::SEQ_B1_B2_B3: g = '{2'h1, 2'h2, 2'h3, 2'h0};
      pgrs_pkg::SEQ_EXT_L2_B12: g = '{2'h3, 2'h3, 2'h0, 2'h2};
      default: g = '{2'h0, 2'h0, 2'h0, 2'h0};
    endcase
    return g[idx];
  endfunction : pgrs_group

  // Synchronised copies of the asynchronous inputs, taken from the second flip-flop only.
  logic comp_s;
  logic [4:0] good_s;
  logic [3:0] pin_s;
  logic undervoltage_lockout_s;
  logic on_s;
  // Stage number of each sequence member under the current code.
  logic [1:0] grp [4];
  logic [3:0] mem_good;
  logic [1:0] last_stage;
  logic stage_done;
  logic rails_fail;
  // Cycle counts for the selected delay, the code 111 gap and the power-down spacing.
  logic [pgrs_pkg::CNT_W-1:0] delay_cyc;
  logic [pgrs_pkg::CNT_W-1:0] gap_cyc;
  logic [pgrs_pkg::CNT_W-1:0] down_cyc;

  // This order must match the order in which sync1 is loaded below.
  assign {comp_s, good_s, pin_s, undervoltage_lockout_s, on_s} = cur.sync2;
  assign mem_good = {good_s[pgrs_pkg::LIN2_BIT], good_s[pgrs_pkg::BUCK3_BIT],
                     good_s[pgrs_pkg::BUCK2_BIT], good_s[pgrs_pkg::BUCK1_BIT]};
  // Counts are cut to the counter width on purpose; the largest default still fits.
  assign gap_cyc = pgrs_pkg::CNT_W'(GAP_CYCLES);
  assign down_cyc = pgrs_pkg::CNT_W'(pgrs_pkg::DOWN_STEP_CYC);

  // The stage map is combinational, so a code change mid-sequence reaches the enables
  // at the next edge without waiting for the sequence to restart.
  for (genvar i = 0; i < 4; i++)
  begin : g_grp
    assign grp[i] = pgrs_group(cur.seq, i, buck_three_pin_override);
  end

  always_comb
  begin
    // Highest stage used by the current code, and whether every member of the present
    // stage reports good. Code 111 overrides its first two stages: stage 1 ends at once, stage 2 after the gap.
    last_stage = 2'h0;
    stage_done = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      if (grp[i] > last_stage)
        last_stage = grp[i];
      if (grp[i] == cur.stage && !mem_good[i])
        stage_done = 1'b0;
    end
    if (cur.seq == pgrs_pkg::SEQ_EXT_L2_B12 && cur.stage == 2'h1)
      stage_done = 1'b1;
    if (cur.seq == pgrs_pkg::SEQ_EXT_L2_B12 && cur.stage == 2'h2)
      stage_done = cur.step_cnt > gap_cyc;

    // One delay field serves both the good output and the reset output.
    case (cur.delay_sel)
      2'h0: delay_cyc = pgrs_pkg::CNT_W'(DELAY0_CYCLES);
      2'h1: delay_cyc = pgrs_pkg::CNT_W'(DELAY1_CYCLES);
      2'h2: delay_cyc = pgrs_pkg::CNT_W'(DELAY2_CYCLES);
      default: delay_cyc = pgrs_pkg::CNT_W'(DELAY3_CYCLES);
    endcase
    // A masked rail that is low or disabled pulls the good output down; the pair mask
    // only does so when both of its rails have failed.
    rails_fail = |(cur.mask[4:0] & ~good_s);
    if (cur.mask[pgrs_pkg::PAIR_MASK_BIT] && !good_s[pgrs_pkg::BUCK3_BIT]
        && !good_s[pgrs_pkg::LIN1_BIT])
      rails_fail = 1'b1;
  end

  always_comb
  begin
    next_cur = cur;
    // Two flip-flops on every asynchronous input before any logic reads it.
    next_cur.sync1 = {reset_comp_below, rail_good_in, buck_one_on_pin, buck_two_on_pin,
                      buck_three_on_pin, linreg_on_pin, undervoltage_lockout, on_state};
    next_cur.sync2 = cur.sync1;
    // Register writes; the status register only takes its delay field.
    if (reg_wr)
    begin
      case (reg_addr)
        pgrs_pkg::STATUS_ADDR:
          next_cur.delay_sel = reg_wdata[pgrs_pkg::DELAY_MSB:pgrs_pkg::DELAY_LSB];
        pgrs_pkg::MASK_ADDR: next_cur.mask = reg_wdata[5:0];
        pgrs_pkg::CTRL_ADDR:
        begin
          next_cur.seq = reg_wdata[pgrs_pkg::SEQ_MSB:pgrs_pkg::SEQ_LSB];
          next_cur.enables = reg_wdata[4:0];
        end
        default: next_cur.rdata = cur.rdata;
      endcase
    end
    // A low pin wins over a write in the same cycle so the bit never sticks cleared.
    if (!pin_s[3])
      next_cur.enables[pgrs_pkg::BUCK1_BIT] = 1'b1;
    if (!pin_s[2])
      next_cur.enables[pgrs_pkg::BUCK2_BIT] = 1'b1;
    if (!pin_s[1])
      next_cur.enables[pgrs_pkg::BUCK3_BIT] = 1'b1;
    if (!pin_s[0])
      next_cur.enables[1:0] = pgrs_pkg::ENABLE_RESET[1:0];
    // Lockout reloads the writable mask and control fields and beats a write in that cycle.
    if (undervoltage_lockout_s)
    begin
      next_cur.mask = pgrs_pkg::MASK_RESET;
      next_cur.seq = SEQ_DEFAULT;
      next_cur.enables = pgrs_pkg::ENABLE_RESET;
    end
    // Reads return the register value as it stood before any write in the same cycle.
    if (reg_rd)
    begin
      case (reg_addr)
        pgrs_pkg::STATUS_ADDR: next_cur.rdata = {comp_s, cur.delay_sel, good_s};
        pgrs_pkg::MASK_ADDR: next_cur.rdata = {2'h0, cur.mask};
        pgrs_pkg::CTRL_ADDR: next_cur.rdata = {cur.seq, cur.enables};
        default: next_cur.rdata = 8'h00;
      endcase
    end
    // Sequencer: climb on ON entry, walk back down the same stages when ON is left.
    // The step counter saturates so a long ON time cannot wrap it into a false step.
    next_cur.step_cnt = (cur.step_cnt == '1) ? cur.step_cnt : cur.step_cnt + 1'b1;
    if (on_s)
    begin
      if (cur.stage == 2'h0 && last_stage != 2'h0)
      begin
        next_cur.stage = 2'h1;
        next_cur.step_cnt = '0;
      end
      else if (cur.stage != 2'h0 && cur.stage < last_stage && stage_done)
      begin
        next_cur.stage = cur.stage + 2'h1;
        next_cur.step_cnt = '0;
      end
    end
    else if (cur.stage != 2'h0 && cur.step_cnt >= down_cyc)
    begin
      next_cur.stage = cur.stage - 2'h1;
      next_cur.step_cnt = '0;
    end
    // Members in the sequence follow the stage; other bucks follow their pin while ON, linreg two its pin at any time.
    // Auto-sequenced bucks ignore their pins, which are expected to be tied low.
    for (int i = 0; i < 3; i++)
    begin
      if (grp[i] != 2'h0)
        next_cur.buck[i] = cur.stage >= grp[i] && cur.enables[pgrs_pkg::BUCK1_BIT - i];
      else
        next_cur.buck[i] = on_s && pin_s[3 - i] && cur.enables[pgrs_pkg::BUCK1_BIT - i];
    end
    if (grp[3] != 2'h0)
      next_cur.lin2 = cur.stage >= grp[3] && cur.enables[pgrs_pkg::LIN2_BIT];
    else
      next_cur.lin2 = pin_s[0] && cur.enables[pgrs_pkg::LIN2_BIT];
    // Linreg one is never sequenced here and is not gated by the ON state.
    next_cur.lin1 = pin_s[0] && cur.enables[pgrs_pkg::LIN1_BIT];
    // The external regulator enable leads the code 111 sequence and drops last.
    next_cur.ext_on = cur.seq == pgrs_pkg::SEQ_EXT_L2_B12 && cur.stage != 2'h0;
    // Delayed release of the good and reset outputs.
    // A failing rail clears the count at once, so the output drops on the next edge.
    if (rails_fail)
      next_cur.good_cnt = '0;
    else if (cur.good_cnt < delay_cyc)
      next_cur.good_cnt = cur.good_cnt + 1'b1;
    next_cur.good_out = !rails_fail && cur.good_cnt >= delay_cyc;
    // The reset output uses the same delay, counted while the comparator is above threshold.
    if (comp_s)
      next_cur.rst_cnt = '0;
    else if (cur.rst_cnt < delay_cyc)
      next_cur.rst_cnt = cur.rst_cnt + 1'b1;
    next_cur.rst_out = !comp_s && cur.rst_cnt >= delay_cyc;
  end

  // Reset loads the register defaults; everything else in the struct starts at zero.
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      cur <= '0;
      cur.delay_sel <= pgrs_pkg::DELAY_RESET;
      cur.mask <= pgrs_pkg::MASK_RESET;
      cur.seq <= SEQ_DEFAULT;
      cur.enables <= pgrs_pkg::ENABLE_RESET;
    end
    else
      cur <= next_cur;
  end

  // All outputs come straight from the registered state.
  assign reg_rdata = cur.rdata;
  assign buck_on = cur.buck;
  assign linreg_one_on = cur.lin1;
  assign linreg_two_on = cur.lin2;
  assign external_regulator_on_out = cur.ext_on;
  assign rails_good_output = cur.good_out;
  assign reset_release_out = cur.rst_out;
endmodule : pgrs_sequencer

// file: sim/pgrs_chk.sv
/* Port assertions for the sequencer.
   Bound to each pgrs_sequencer; one clock with synchronous reset. */
`timescale 1ns/100ps
module pgrs_chk #(
  parameter int DELAY0_CYCLES = 20,
  parameter logic [2:0] SEQ_DEFAULT = 3'h0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic reset_comp_below,
  input wire logic linreg_on_pin,
  input wire logic undervoltage_lockout,
  input wire logic linreg_one_on,
  input wire logic linreg_two_on,
  input wire logic external_regulator_on_out,
  input wire logic rails_good_output,
  input wire logic reset_release_out
);
  int lo_g;
  int lo_r;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // Low-time counters: no release may come sooner than the shortest delay code.
  always_ff @(posedge ref_clk)
  begin
    lo_g <= (!resetn || rails_good_output) ? 0 : lo_g + 1;
    lo_r <= (!resetn || reset_release_out) ? 0 : lo_r + 1;
  end
  a_good_wait: assert property ($rose(rails_good_output) |-> lo_g >= DELAY0_CYCLES)
    else $error("good output released early");
  a_rst_wait: assert property ($rose(reset_release_out) |-> lo_r >= DELAY0_CYCLES)
    else $error("reset output released early");
  a_comp_hold: assert property (reset_comp_below [*3] |=> !reset_release_out)
    else $error("reset released while comparator below");
  a_lin1_off: assert property (!linreg_on_pin [*3] |=> !linreg_one_on)
    else $error("linreg one on with pin low");
  a_unmap_zero: assert property (reg_rd && !(reg_addr inside {[8'h0b:8'h0d]})
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mask_top: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata[7:6] == 2'h0)
    else $error("mask top bits not zero");
  a_undervoltage_lockout_ctrl: assert property (undervoltage_lockout [*4] ##0 (reg_rd && reg_addr == 8'h0d)
    |=> reg_rdata == {SEQ_DEFAULT, 5'h1f})
    else $error("control not at default under lockout");
  a_ext_first: assert property ($rose(external_regulator_on_out) |-> !linreg_two_on)
    else $error("linreg two before external enable");
endmodule : pgrs_chk
bind pgrs_sequencer pgrs_chk #(.DELAY0_CYCLES(DELAY0_CYCLES), .SEQ_DEFAULT(SEQ_DEFAULT)) u_chk (
  .ref_clk, .resetn, .reg_rd, .reg_addr, .reg_rdata, .reset_comp_below, .linreg_on_pin,
  .undervoltage_lockout, .linreg_one_on, .linreg_two_on, .external_regulator_on_out,
  .rails_good_output, .reset_release_out);

// file: sim/pgrs_rail_model.sv
/* Rail model: each rail reports good a few cycles after its enable.
   Assumes registered enables on ref_clk; fault forces a rail bad. */
`timescale 1ns/100ps
module pgrs_rail_model #(
  parameter int RAMP = 4
) (
  input wire logic ref_clk,
  input wire logic [4:0] rail_on,
  input wire logic [4:0] fault,
  output logic [4:0] rail_good_in
);
  int age [5];
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 5; i++)
    begin
      age[i] <= rail_on[i] ? age[i] + 1 : 0;
      rail_good_in[i] <= rail_on[i] && !fault[i] && age[i] >= RAMP;
    end
  end
endmodule : pgrs_rail_model

// file: sim/pgrs_sequencer_bench.sv
/* Self-checking bench for pgrs_sequencer with the rail model.
   Uses shortened delay and gap parameters. */
`timescale 1ns/100ps
module pgrs_sequencer_bench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reset_comp_below = 1'b0;
  logic [4:0] rail_good_in;
  logic buck_one_on_pin = 1'b0;
  logic buck_two_on_pin = 1'b0;
  logic buck_three_on_pin = 1'b0;
  logic linreg_on_pin = 1'b0;
  logic undervoltage_lockout = 1'b0;
  logic on_state = 1'b0;
  logic buck_three_pin_override = 1'b1;
  logic [2:0] buck_on;
  logic linreg_one_on;
  logic linreg_two_on;
  logic external_regulator_on_out;
  logic rails_good_output;
  logic reset_release_out;
  logic [4:0] fault = 5'h00;
  int err_total = 0;
  int n_tests = 0;
  int n;
  wire [7:0] en = {reset_release_out, rails_good_output, external_regulator_on_out,
    linreg_two_on, linreg_one_on, buck_on};
  pgrs_sequencer #(.DELAY0_CYCLES(20), .DELAY1_CYCLES(40), .DELAY2_CYCLES(60),
    .DELAY3_CYCLES(80), .GAP_CYCLES(10)) u_dut (.ref_clk, .resetn, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reset_comp_below, .rail_good_in, .buck_one_on_pin,
    .buck_two_on_pin, .buck_three_on_pin, .linreg_on_pin, .undervoltage_lockout, .on_state,
    .buck_three_pin_override, .buck_on, .linreg_one_on, .linreg_two_on,
    .external_regulator_on_out, .rails_good_output, .reset_release_out);
  pgrs_rail_model u_rails (.ref_clk, .rail_on({buck_on[0], buck_on[1], buck_on[2],
    linreg_one_on, linreg_two_on}), .fault, .rail_good_in);
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Writes end one idle edge later so back-to-back strobes never collide.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk("reg_rdata", e, reg_rdata);
  endtask : rc
  task automatic wt(input int i, input logic v);
    n = 0;
    while (en[i] !== v && n < 400)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk("output level", {7'h0, v}, {7'h0, en[i]});
  endtask : wt
  task automatic t_regs();
    rc(8'h0b, 8'h60);
    rc(8'h20, 8'h00);
    wr(8'h0c, 8'hff);
    rc(8'h0c, 8'h3f);
    wr(8'h0b, 8'h9f);
    rc(8'h0b, 8'h00);
    undervoltage_lockout <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rc(8'h0d, 8'h1f);
    rc(8'h0c, 8'h10);
    undervoltage_lockout <= 1'b0;
    // Lockout leaves the synchroniser three edges later; an earlier write would be lost.
    repeat (3) @(posedge ref_clk);
    $display("register test done");
  endtask : t_regs
  task automatic t_seq6();
    wr(8'h0d, 8'hdf);
    on_state <= 1'b1;
    wt(0, 1'b1);
    chk("buck two", 8'h0, {7'h0, buck_on[1]});
    wt(1, 1'b1);
    chk("buck three", 8'h0, {7'h0, buck_on[2]});
    wt(2, 1'b1);
    wt(6, 1'b1);
    on_state <= 1'b0;
    wt(2, 1'b0);
    chk("buck two", 8'h1, {7'h0, buck_on[1]});
    wt(1, 1'b0);
    chk("buck one", 8'h1, {7'h0, buck_on[0]});
    wt(6, 1'b0);
    $display("order 110 test done");
  endtask : t_seq6
  task automatic t_seq7();
    wr(8'h0d, 8'hff);
    on_state <= 1'b1;
    wt(5, 1'b1);
    chk("linreg two", 8'h0, {7'h0, linreg_two_on});
    wt(4, 1'b1);
    wt(0, 1'b1);
    chk("gap", 8'h1, {7'h0, n > 10});
    chk("buck two", 8'h1, {7'h0, buck_on[1]});
    on_state <= 1'b0;
    wt(0, 1'b0);
    chk("linreg two", 8'h1, {7'h0, linreg_two_on});
    wt(5, 1'b0);
    $display("order 111 test done");
  endtask : t_seq7
  task automatic t_codes();
    wr(8'h0d, 8'h5f);
    on_state <= 1'b1;
    wt(0, 1'b1);
    chk("buck two", 8'h0, {7'h0, buck_on[1]});
    wt(1, 1'b1);
    chk("buck three", 8'h1, {7'h0, buck_on[2]});
    on_state <= 1'b0;
    wt(0, 1'b0);
    chk("buck three", 8'h0, {7'h0, buck_on[2]});
    wr(8'h0d, 8'h7f);
    on_state <= 1'b1;
    wt(2, 1'b1);
    chk("buck two", 8'h0, {7'h0, buck_on[1]});
    wt(1, 1'b1);
    chk("buck one", 8'h0, {7'h0, buck_on[0]});
    on_state <= 1'b0;
    wt(1, 1'b0);
    chk("buck three", 8'h1, {7'h0, buck_on[2]});
    wt(2, 1'b0);
    wr(8'h0d, 8'h9f);
    on_state <= 1'b1;
    wt(4, 1'b1);
    chk("buck three", 8'h1, {7'h0, buck_on[2]});
    chk("buck one", 8'h0, {7'h0, buck_on[0]});
    wt(0, 1'b1);
    chk("buck two", 8'h1, {7'h0, buck_on[1]});
    buck_three_pin_override <= 1'b0;
    wt(2, 1'b0);
    on_state <= 1'b0;
    wt(4, 1'b0);
    chk("buck one", 8'h0, {7'h0, buck_on[0]});
    buck_three_pin_override <= 1'b1;
    wr(8'h0d, 8'h3f);
    on_state <= 1'b1;
    wt(1, 1'b1);
    chk("buck three", 8'h1, {7'h0, buck_on[2]});
    chk("buck one", 8'h0, {7'h0, buck_on[0]});
    wr(8'h0d, 8'h1f);
    wt(2, 1'b0);
    chk("buck two", 8'h1, {7'h0, buck_on[1]});
    on_state <= 1'b0;
    wt(1, 1'b0);
    $display("order table test done");
  endtask : t_codes
  task automatic t_pins();
    wr(8'h0d, 8'hbf);
    on_state <= 1'b1;
    buck_two_on_pin <= 1'b1;
    wt(1, 1'b1);
    chk("buck one", 8'h0, {7'h0, buck_on[0]});
    wr(8'h0d, 8'hb7);
    wt(1, 1'b0);
    buck_two_on_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rc(8'h0d, 8'hbf);
    $display("pin test done");
  endtask : t_pins
  task automatic t_good();
    linreg_on_pin <= 1'b1;
    wr(8'h0c, 8'h02);
    wt(3, 1'b1);
    wt(6, 1'b1);
    fault <= 5'h02;
    wt(6, 1'b0);
    chk("drop time", 8'h1, {7'h0, n <= 6});
    fault <= 5'h00;
    buck_three_on_pin <= 1'b1;
    wt(2, 1'b1);
    wr(8'h0c, 8'h20);
    wt(6, 1'b1);
    fault <= 5'h02;
    repeat (30) @(posedge ref_clk);
    chk("good output", 8'h1, {7'h0, rails_good_output});
    fault <= 5'h06;
    wt(6, 1'b0);
    fault <= 5'h00;
    reset_comp_below <= 1'b1;
    wt(7, 1'b0);
    rc(8'h0b, 8'h87);
    reset_comp_below <= 1'b0;
    linreg_on_pin <= 1'b0;
    wt(3, 1'b0);
    $display("good output test done");
  endtask : t_good
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_seq6();
    t_seq7();
    t_codes();
    t_pins();
    t_good();
    stop_test();
  end
  // The tests need under two thousand cycles; this limit only catches a hang.
  initial
  begin
    repeat (6000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
endmodule : pgrs_sequencer_bench
